//--- rtl/pfc_defines.vh
// Contract
// - smallest variant: sector and chip erase, no block erase
// - chip erase is six cycles ending 10h
// - sector erase: prefix then 30h at sector
// - block erase: prefix then 50h at block
// - program: three unlock cycles then address/data
// - AAh,55h,90h enters identification mode
// - id exit by three cycles or single F0h
// - toggle bit advances on every read access; the model advances it only on reads while busy
// - inverted-data bit fixed while busy: 0 for erase, complement of bit 7 for program
// - read only with ce, oe low, we high
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH
`define PFC_AW 19
`define PFC_ADDR_UNLOCK1 19'h00555
`define PFC_ADDR_UNLOCK2 19'h002aa
`define PFC_ADDR_ID_MAKER 19'h00000
`define PFC_ADDR_ID_DEV 19'h00001
`define PFC_SECTOR_LSB 12
`define PFC_BLOCK_LSB 16
`define PFC_DAT_UNLOCK1 8'haa
`define PFC_DAT_UNLOCK2 8'h55
`define PFC_DAT_SETUP 8'h80
`define PFC_DAT_CHIP 8'h10
`define PFC_DAT_SECTOR 8'h30
`define PFC_DAT_BLOCK 8'h50
`define PFC_DAT_PROG 8'ha0
`define PFC_DAT_ID_ENTER 8'h90
`define PFC_DAT_ID_EXIT 8'hf0
`define PFC_CMD_READ 3'h0
`define PFC_CMD_PROG 3'h1
`define PFC_CMD_SECTOR 3'h2
`define PFC_CMD_BLOCK 3'h3
`define PFC_CMD_CHIP 3'h4
`define PFC_CMD_ID_ENTER 3'h5
`define PFC_CMD_ID_EXIT 3'h6
`define PFC_CMD_ID_EXIT1 3'h7
`define PFC_CLK_MHZ 100
`define PFC_PROG_TIME_US 40
`define PFC_ERASE_TIME_MS 100
`define PFC_PROG_CYC (`PFC_PROG_TIME_US * `PFC_CLK_MHZ)
`define PFC_ERASE_CYC (`PFC_ERASE_TIME_MS * 1000 * `PFC_CLK_MHZ)
`define PFC_SETUP_CYC 4'h4
`define PFC_PULSE_CYC 4'h4
`define PFC_HOLD_CYC 4'h3
`define PFC_READ_CYC 4'h8
`define PFC_GAP_CYC 4'h3
`define PFC_BIT_DPOLL 7
`define PFC_BIT_TOGGLE 6
`endif

//--- rtl/pfc_bus_cycle.v
`timescale 1ns/1ps
`include "pfc_defines.vh"
// one write or read bus cycle on the flash pins
module pfc_bus_cycle (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // request
    input wire req_valid,
    input wire req_write,
    input wire [18:0] req_addr,
    input wire [7:0] req_wdata,
    output wire req_ready,
    output reg done_q,
    output reg [7:0] rdata_q,
    // flash pins
    output reg [18:0] fl_addr_q,
    output reg [7:0] fl_dq_out_q,
    output reg fl_dq_oe_n_q,
    input wire [7:0] fl_dq_in,
    output reg fl_ce_n_q,
    output reg fl_oe_n_q,
    output reg fl_we_n_q
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_PULSE = 3'h2;
    localparam ST_HOLD = 3'h3;
    localparam ST_GAP = 3'h4;

    reg [2:0] st_q;
    reg [3:0] cnt_q;
    reg wr_q;
    reg [7:0] dq_s1_q;
    reg [7:0] dq_s2_q;

    assign req_ready = (st_q == ST_IDLE);

    // data pins are asynchronous to clk
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= fl_dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            fl_addr_q <= 19'h00000;
            fl_dq_out_q <= 8'h00;
            fl_dq_oe_n_q <= 1'b1;
            fl_ce_n_q <= 1'b1;
            fl_oe_n_q <= 1'b1;
            fl_we_n_q <= 1'b1;
        end else begin
            done_q <= 1'b0;
            cnt_q <= cnt_q - 4'h1;
            case (st_q)
            ST_IDLE: begin
                if (req_valid) begin
                    wr_q <= req_write;
                    fl_addr_q <= req_addr;
                    fl_dq_out_q <= req_wdata;
                    // oe high before any write strobe
                    fl_oe_n_q <= 1'b1;
                    fl_ce_n_q <= 1'b0;
                    cnt_q <= `PFC_SETUP_CYC;
                    st_q <= ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_q == 4'h0) begin
                    if (wr_q) begin
                        // we falls after ce: address taken here
                        fl_we_n_q <= 1'b0;
                        fl_dq_oe_n_q <= 1'b0;
                        cnt_q <= `PFC_PULSE_CYC;
                    end else begin
                        // read with we held high
                        fl_oe_n_q <= 1'b0;
                        cnt_q <= `PFC_READ_CYC;
                    end
                    st_q <= ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cnt_q == 4'h0) begin
                    if (wr_q) begin
                        // we rises first; data held past it
                        fl_we_n_q <= 1'b1;
                    end else begin
                        rdata_q <= dq_s2_q;
                        fl_oe_n_q <= 1'b1;
                    end
                    cnt_q <= `PFC_HOLD_CYC;
                    st_q <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_q == 4'h0) begin
                    // ce rises every cycle so each read is new
                    fl_ce_n_q <= 1'b1;
                    fl_dq_oe_n_q <= 1'b1;
                    cnt_q <= `PFC_GAP_CYC;
                    st_q <= ST_GAP;
                end
            end
            ST_GAP: begin
                if (cnt_q == 4'h0) begin
                    done_q <= 1'b1;
                    st_q <= ST_IDLE;
                end
            end
            default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- rtl/pfc_host.v
`timescale 1ns/1ps
`include "pfc_defines.vh"
// host controller: issues command sequences and polls for completion
module pfc_host #(
    parameter PROG_CYC = `PFC_PROG_CYC,
    parameter ERASE_CYC = `PFC_ERASE_CYC,
    parameter HAS_BLOCK_ERASE = 1
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // command port
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire [18:0] cmd_addr,
    input wire [7:0] cmd_wdata,
    output wire cmd_ready,
    output reg cmd_done_q,
    output reg cmd_err_q,
    output reg [7:0] cmd_rdata_q,
    output reg id_mode_q,
    // flash pins
    output wire [18:0] fl_addr,
    output wire [7:0] fl_dq_out,
    output wire fl_dq_oe_n,
    input wire [7:0] fl_dq_in,
    output wire fl_ce_n,
    output wire fl_oe_n,
    output wire fl_we_n
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ISSUE = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_POLL = 3'h3;
    localparam ST_PWAIT = 3'h4;
    localparam ST_FIN = 3'h5;

    reg [2:0] st_q;
    reg [2:0] op_q;
    reg [18:0] addr_q;
    reg [7:0] wdata_q;
    reg [2:0] step_q;
    reg [2:0] nsteps;
    reg have_prev_q;
    reg prev_tog_q;
    reg [31:0] tmo_q;
    reg bc_valid;
    reg bc_write;
    reg [18:0] bc_addr;
    reg [7:0] bc_wdata;
    wire bc_ready;
    wire bc_done;
    wire [7:0] bc_rdata;
    wire busy_op;
    wire is_erase;
    wire poll_line_seven;
    wire poll_line_six;
    wire toggled;
    wire settled;

    assign cmd_ready = (st_q == ST_IDLE);
    assign is_erase = (op_q == `PFC_CMD_SECTOR) || (op_q == `PFC_CMD_BLOCK)
        || (op_q == `PFC_CMD_CHIP);
    assign busy_op = is_erase || (op_q == `PFC_CMD_PROG);
    assign poll_line_seven = bc_rdata[`PFC_BIT_DPOLL];
    assign poll_line_six = bc_rdata[`PFC_BIT_TOGGLE];
    assign toggled = have_prev_q && (poll_line_six != prev_tog_q);
    // erase ends with one, program with the true bit
    assign settled = is_erase ? poll_line_seven
        : (poll_line_seven == wdata_q[`PFC_BIT_DPOLL]);

    // sequence length per command
    always @* begin
        case (op_q)
        `PFC_CMD_PROG: nsteps = 3'h4;
        `PFC_CMD_SECTOR: nsteps = 3'h6;
        `PFC_CMD_BLOCK: nsteps = 3'h6;
        `PFC_CMD_CHIP: nsteps = 3'h6;
        `PFC_CMD_ID_ENTER: nsteps = 3'h3;
        `PFC_CMD_ID_EXIT: nsteps = 3'h3;
        `PFC_CMD_ID_EXIT1: nsteps = 3'h1;
        default: nsteps = 3'h1;
        endcase
    end

    // bus cycle for the current step
    always @* begin
        bc_write = 1'b1;
        bc_addr = `PFC_ADDR_UNLOCK1;
        bc_wdata = `PFC_DAT_UNLOCK1;
        bc_valid = 1'b0;
        if (st_q == ST_ISSUE) begin
            bc_valid = 1'b1;
            if (op_q == `PFC_CMD_READ) begin
                // in id mode only the low two bits matter
                bc_write = 1'b0;
                bc_addr = addr_q;
            end else if (op_q == `PFC_CMD_ID_EXIT1) begin
                bc_addr = addr_q;
                bc_wdata = `PFC_DAT_ID_EXIT;
            end else begin
                case (step_q)
                3'h0: bc_wdata = `PFC_DAT_UNLOCK1;
                3'h1: begin
                    bc_addr = `PFC_ADDR_UNLOCK2;
                    bc_wdata = `PFC_DAT_UNLOCK2;
                end
                3'h2: begin
                    case (op_q)
                    `PFC_CMD_PROG: bc_wdata = `PFC_DAT_PROG;
                    `PFC_CMD_ID_ENTER: bc_wdata = `PFC_DAT_ID_ENTER;
                    `PFC_CMD_ID_EXIT: bc_wdata = `PFC_DAT_ID_EXIT;
                    default: bc_wdata = `PFC_DAT_SETUP;
                    endcase
                    if (op_q == `PFC_CMD_PROG) begin
                        bc_wdata = `PFC_DAT_PROG;
                    end
                end
                3'h3: begin
                    if (op_q == `PFC_CMD_PROG) begin
                        bc_addr = addr_q;
                        bc_wdata = wdata_q;
                    end else begin
                        bc_wdata = `PFC_DAT_UNLOCK1;
                    end
                end
                3'h4: begin
                    bc_addr = `PFC_ADDR_UNLOCK2;
                    bc_wdata = `PFC_DAT_UNLOCK2;
                end
                default: begin
                    case (op_q)
                    `PFC_CMD_SECTOR: begin
                        bc_addr = {addr_q[18:`PFC_SECTOR_LSB],
                            12'h000};
                        bc_wdata = `PFC_DAT_SECTOR;
                    end
                    `PFC_CMD_BLOCK: begin
                        bc_addr = {addr_q[18:`PFC_BLOCK_LSB],
                            16'h0000};
                        bc_wdata = `PFC_DAT_BLOCK;
                    end
                    default: bc_wdata = `PFC_DAT_CHIP;
                    endcase
                end
                endcase
            end
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            op_q <= `PFC_CMD_READ;
            addr_q <= 19'h00000;
            wdata_q <= 8'h00;
            step_q <= 3'h0;
            have_prev_q <= 1'b0;
            prev_tog_q <= 1'b0;
            tmo_q <= 32'h0;
            cmd_done_q <= 1'b0;
            cmd_err_q <= 1'b0;
            cmd_rdata_q <= 8'h00;
            id_mode_q <= 1'b0;
        end else begin
            cmd_done_q <= 1'b0;
            if (tmo_q != 32'h0) begin
                tmo_q <= tmo_q - 32'h1;
            end
            case (st_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    op_q <= cmd_op;
                    addr_q <= cmd_addr;
                    wdata_q <= cmd_wdata;
                    step_q <= 3'h0;
                    cmd_err_q <= 1'b0;
                    if (cmd_op == `PFC_CMD_BLOCK && HAS_BLOCK_ERASE == 0) begin
                        cmd_err_q <= 1'b1;
                        st_q <= ST_FIN;
                    end else begin
                        st_q <= ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                if (bc_ready) begin
                    st_q <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (bc_done) begin
                    if (op_q == `PFC_CMD_READ) begin
                        cmd_rdata_q <= bc_rdata;
                        st_q <= ST_FIN;
                    end else if (step_q + 3'h1 < nsteps) begin
                        step_q <= step_q + 3'h1;
                        st_q <= ST_ISSUE;
                    end else if (busy_op) begin
                        have_prev_q <= 1'b0;
                        tmo_q <= is_erase ? ERASE_CYC : PROG_CYC;
                        st_q <= ST_POLL;
                    end else begin
                        // mode follows the whole sequence
                        id_mode_q <= (op_q == `PFC_CMD_ID_ENTER);
                        st_q <= ST_FIN;
                    end
                end
            end
            ST_POLL: begin
                if (bc_ready) begin
                    st_q <= ST_PWAIT;
                end
            end
            ST_PWAIT: begin
                if (bc_done) begin
                    have_prev_q <= 1'b1;
                    prev_tog_q <= poll_line_six;
                    if (have_prev_q && !toggled && settled) begin
                        cmd_rdata_q <= bc_rdata;
                        st_q <= ST_FIN;
                    end else if (tmo_q == 32'h0) begin
                        cmd_err_q <= 1'b1;
                        st_q <= ST_FIN;
                    end else begin
                        st_q <= ST_POLL;
                    end
                end
            end
            ST_FIN: begin
                cmd_done_q <= 1'b1;
                st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
            endcase
        end
    end

    wire poll_req = (st_q == ST_POLL);

    pfc_bus_cycle u_bus (
        .clk(clk),
        .sys_rst(sys_rst),
        .req_valid(bc_valid | poll_req),
        .req_write(bc_write & ~poll_req),
        .req_addr(poll_req ? addr_q : bc_addr),
        .req_wdata(bc_wdata),
        .req_ready(bc_ready),
        .done_q(bc_done),
        .rdata_q(bc_rdata),
        .fl_addr_q(fl_addr),
        .fl_dq_out_q(fl_dq_out),
        .fl_dq_oe_n_q(fl_dq_oe_n),
        .fl_dq_in(fl_dq_in),
        .fl_ce_n_q(fl_ce_n),
        .fl_oe_n_q(fl_oe_n),
        .fl_we_n_q(fl_we_n)
    );
endmodule

//--- dv/pfc_flash_model.sv
`timescale 1ns/1ps
// behavioural flash device on the far side of the host pins
module pfc_flash_model #(
    parameter MAKER = 8'h5a, // arbitrary value
    parameter DEV = 8'hc3, // arbitrary value
    parameter HAS_BLOCK = 1
) (
    // host pins
    input wire [18:0] fl_addr,
    input wire [7:0] fl_dq_out,
    input wire fl_dq_oe_n,
    output wire [7:0] fl_dq_in,
    input wire fl_ce_n,
    input wire fl_oe_n,
    input wire fl_we_n
);
    reg [7:0] mem [0:20'h7ffff];
    reg [18:0] a_q;
    reg [7:0] last_q, held;
    reg [2:0] st;
    reg id_q, busy, ers, tog;
    integer prog_ns = 1000, ers_ns = 5000, i;
    wire wr_n = fl_ce_n | fl_we_n;
    wire rd_n = fl_ce_n | fl_oe_n;
    wire rd = !rd_n && fl_we_n;
    // undriven data lines read back as garbage, not the last byte
    wire [7:0] din = fl_dq_oe_n ? ~last_q : fl_dq_out;
    wire [7:0] idv = fl_addr[1:0] == 2'h0 ? MAKER :
        fl_addr[1:0] == 2'h1 ? DEV : 8'h00;
    wire [7:0] dout = busy ? {ers ? 1'b0 : ~last_q[7], tog,
        last_q[5:0]} : id_q ? idv : mem[fl_addr];
    assign fl_dq_in = rd ? dout : ~held;
    always @* if (rd) held = dout;
    initial begin
        for (i = 0; i < 20'h80000; i = i + 1) mem[i] = 8'hff;
        {st, id_q, busy, ers, tog, last_q, held} = 0;
    end
    always @(negedge rd_n) if (busy) tog = ~tog;
    always @(negedge wr_n) a_q = fl_addr;
    // erase and program lock out further commands until done
    always @(posedge wr_n) if (fl_oe_n && !busy) step(a_q, din);
    task erase(input [18:0] lo, input integer n);
        begin
            for (i = 0; i < n; i = i + 1) mem[lo + i] = 8'hff;
            ers = 1;
            busy = 1;
            busy <= #(ers_ns) 1'b0;
        end
    endtask
    task step(input [18:0] a, input [7:0] d);
        reg u1, u2;
        begin
            u1 = a == 19'h00555;
            u2 = a == 19'h002aa;
            case (st)
            3'h0: begin
                if (id_q && d == 8'hf0) id_q = 0;
                st = (u1 && d == 8'haa) ? 3'h1 : 3'h0;
            end
            3'h1, 3'h4: st = (u2 && d == 8'h55) ? st + 3'h1 : 3'h0;
            3'h2: begin
                st = (u1 && d == 8'ha0) ? 3'h6 : 3'h0;
                if (u1 && d == 8'h80) st = 3'h3;
                if (u1 && d == 8'h90) id_q = 1;
                if (u1 && d == 8'hf0) id_q = 0;
            end
            3'h3: st = (u1 && d == 8'haa) ? 3'h4 : 3'h0;
            3'h5: begin
                st = 3'h0;
                if (u1 && d == 8'h10) erase(19'h0, 20'h80000);
                if (d == 8'h30) erase({a[18:12], 12'h0}, 13'h1000);
                if (d == 8'h50 && HAS_BLOCK)
                    erase({a[18:16], 16'h0}, 17'h10000);
            end
            3'h6: begin
                st = 3'h0;
                mem[a] = mem[a] & d;
                last_q = d;
                ers = 0;
                busy = 1;
                busy <= #(prog_ns) 1'b0;
            end
            default: st = 3'h0;
            endcase
        end
    endtask
endmodule

//--- dv/pfc_host_monitor.sv
`timescale 1ns/1ps
module pfc_host_monitor #(
    parameter PROG_CYC = 300
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // command port
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire cmd_ready,
    input wire cmd_done_q,
    // flash pins
    input wire [18:0] fl_addr,
    input wire [7:0] fl_dq_out,
    input wire fl_dq_oe_n,
    input wire fl_ce_n,
    input wire fl_oe_n,
    input wire fl_we_n
);
    // four writes plus poll reads around the timeout
    localparam int PROG_LIM = PROG_CYC + 240;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rd; !fl_oe_n |-> fl_we_n && !fl_ce_n && fl_dq_oe_n; endproperty
    a_rd: assert property (p_rd) else $error("bad read strobes");
    property p_wr; !fl_we_n |-> fl_oe_n && !fl_ce_n && !fl_dq_oe_n; endproperty
    a_wr: assert property (p_wr) else $error("bad write strobes");
    property p_hold;
        !fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("write data moved");
    property p_wep; $fell(fl_we_n) |-> (!fl_we_n)[*5] ##1 fl_we_n; endproperty
    a_wep: assert property (p_wep) else $error("write pulse width");
    property p_ceh; $rose(fl_we_n) |-> !fl_ce_n ##4 fl_ce_n; endproperty
    a_ceh: assert property (p_ceh) else $error("select hold");
    property p_oep; $fell(fl_oe_n) |-> !fl_ce_n ##9 $rose(fl_oe_n); endproperty
    a_oep: assert property (p_oep) else $error("read pulse width");
    property p_idle; cmd_ready |-> fl_ce_n && fl_we_n && fl_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("strobes while idle");
    property p_prog;
        cmd_valid && cmd_ready && cmd_op == 3'h1 |-> ##[80:PROG_LIM] cmd_done_q;
    endproperty
    a_prog: assert property (p_prog) else $error("program too long");
endmodule
bind pfc_host pfc_host_monitor #(.PROG_CYC(PROG_CYC)) u_mon (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ready(cmd_ready), .cmd_done_q(cmd_done_q), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

//--- dv/parallel_flash_command_set_test.sv
`timescale 1ns/1ps
module parallel_flash_command_set_test;
    localparam [7:0] MAKER_ID = 8'h5a; // arbitrary value
    localparam [7:0] DEV_ID = 8'hc3; // arbitrary value
    reg clk = 0, sys_rst = 1, cmd_valid = 0, cmd_valid_s = 0;
    wire sm_done, sm_err, sm_ce_n;
    reg [2:0] cmd_op = 0;
    reg [18:0] cmd_addr = 0;
    reg [7:0] cmd_wdata = 0;
    wire cmd_ready, cmd_done_q, cmd_err_q, id_mode_q;
    wire fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
    wire [7:0] cmd_rdata_q, fl_dq_out, fl_dq_in;
    wire [18:0] fl_addr;
    integer fail_count = 0, n_tests = 0;
    always #5 clk = ~clk;
    pfc_host #(.PROG_CYC(300), .ERASE_CYC(2000)) DUT (.clk(clk),
        .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
        .cmd_rdata_q(cmd_rdata_q), .id_mode_q(id_mode_q), .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in),
        .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
    pfc_flash_model #(.MAKER(MAKER_ID), .DEV(DEV_ID)) u_fl (
        .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n),
        .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n));
    // smallest variant: no flash behind it, only the refusal is looked at
    pfc_host #(.PROG_CYC(300), .ERASE_CYC(2000),
        .HAS_BLOCK_ERASE(0)) u_small (.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid_s), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(), .cmd_done_q(sm_done),
        .cmd_err_q(sm_err), .cmd_rdata_q(), .id_mode_q(), .fl_addr(),
        .fl_dq_out(), .fl_dq_oe_n(), .fl_dq_in(8'hff), .fl_ce_n(sm_ce_n),
        .fl_oe_n(), .fl_we_n());
    task ck(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks=%0d mismatches=%0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // bound covers the longest erase plus its poll timeout
    task run(input [2:0] op, input [18:0] a, input [7:0] d);
        integer k;
        begin
            @(negedge clk);
            cmd_op = op;
            cmd_addr = a;
            cmd_wdata = d;
            cmd_valid = 1;
            @(negedge clk);
            cmd_valid = 0;
            for (k = 0; k < 9000 && cmd_done_q !== 1'b1; k = k + 1)
                @(negedge clk);
            ck(cmd_done_q, 8'h01);
        end
    endtask
    task rd(input [18:0] a, input [7:0] e);
        begin
            run(3'h0, a, 8'h00);
            ck(cmd_rdata_q, e);
        end
    endtask
    task t_reset;
        begin
            ck({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n}, 8'h0f);
            ck({cmd_ready, id_mode_q}, 8'h02);
        end
    endtask
    task t_prog;
        begin
            run(3'h1, 19'h12345, 8'h5a);
            ck({cmd_err_q, u_fl.busy}, 8'h00);
            rd(19'h12345, 8'h5a);
            run(3'h1, 19'h12345, 8'h0f);
            rd(19'h12345, 8'h0a);
            run(3'h1, 19'h13000, 8'h3c);
        end
    endtask
    task t_erase;
        begin
            run(3'h2, 19'h12abc, 8'h00);
            ck({cmd_err_q, u_fl.busy}, 8'h00);
            rd(19'h12345, 8'hff);
            rd(19'h13000, 8'h3c);
            run(3'h1, 19'h25000, 8'h11);
            run(3'h1, 19'h30000, 8'h22);
            run(3'h3, 19'h2f123, 8'h00);
            rd(19'h25000, 8'hff);
            rd(19'h30000, 8'h22);
            run(3'h4, 19'h00000, 8'h00);
            rd(19'h30000, 8'hff);
            rd(19'h13000, 8'hff);
        end
    endtask
    // both exit forms, one per pass
    task t_id;
        integer j;
        begin
            for (j = 6; j < 8; j = j + 1) begin
                run(3'h5, 19'h00000, 8'h00);
                ck(id_mode_q, 8'h01);
                rd(19'h7fffc, MAKER_ID);
                rd(19'h40001, DEV_ID);
                run(j[2:0], 19'h04567, 8'h00);
                ck(id_mode_q, 8'h00);
                rd(19'h30000, 8'hff);
            end
        end
    endtask
    // block erase refused at once, select never driven
    task t_small;
        integer k;
        begin
            @(negedge clk);
            cmd_op = 3'h3;
            cmd_addr = 19'h20000;
            cmd_valid_s = 1;
            @(negedge clk);
            cmd_valid_s = 0;
            for (k = 0; k < 20 && sm_done !== 1'b1; k = k + 1)
                @(negedge clk);
            ck({sm_done, sm_err, sm_ce_n}, 8'h07);
        end
    endtask
    // device slower than the poll timeout (20000 ns program); left busy, so it runs last
    task t_slow;
        begin
            u_fl.prog_ns = 20000;
            run(3'h1, 19'h00100, 8'h00);
            ck(cmd_err_q, 8'h01);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        t_reset;
        t_prog;
        t_erase;
        t_id;
        t_small;
        t_slow;
        conclude;
    end
    initial begin
        #500000;
        fail_count = fail_count + 1;
        conclude;
    end
endmodule
